// ### core/pfs_pkg.sv
package pfs_pkg;

	// ========================================
	// Register byte offsets
	localparam logic [11:0] PFS_OFF_PD_LOW   = 12'h000;
	localparam logic [11:0] PFS_OFF_PD_HIGH  = 12'h004;
	localparam logic [11:0] PFS_OFF_PE_LOW   = 12'h008;
	localparam logic [11:0] PFS_OFF_PE_HIGH  = 12'h00C;
	localparam logic [11:0] PFS_OFF_PF_LOW   = 12'h010;
	localparam logic [11:0] PFS_OFF_PF_HIGH  = 12'h014;
	localparam logic [11:0] PFS_OFF_IRQ_SRC  = 12'h018;
	localparam logic [11:0] PFS_OFF_TMA_SRC  = 12'h01C;
	localparam logic [11:0] PFS_OFF_TMB_SRC  = 12'h020;
	localparam logic [11:0] PFS_OFF_SER_SRC  = 12'h024;
	localparam logic [11:0] PFS_OFF_CMP_SRC  = 12'h028;

	// ========================================
	// Reset values and implemented-bit masks of the input selectors
	localparam logic [7:0] PFS_RESET_VAL    = 8'h00;
	localparam logic [7:0] PFS_MASK_IRQ     = 8'h8F;
	localparam logic [7:0] PFS_MASK_TMA     = 8'h7E;
	localparam logic [7:0] PFS_MASK_TMB     = 8'h3E;
	localparam logic [7:0] PFS_MASK_SER     = 8'h3F;
	localparam logic [7:0] PFS_MASK_CMP     = 8'h1B;

	// ========================================
	// Pad function codes
	localparam logic [1:0] PFS_FN_GPIO      = 2'h0;
	localparam logic [1:0] PFS_FN_ALT1      = 2'h1;
	localparam logic [1:0] PFS_FN_ALT2      = 2'h2;
	localparam logic [1:0] PFS_FN_LCD       = 2'h3;

	// AXI responses
	localparam logic [1:0] PFS_RESP_OKAY    = 2'h0;
	localparam logic [1:0] PFS_RESP_SLVERR  = 2'h2;

endpackage : pfs_pkg

// ### core/pfs_mux.sv
`timescale 1ns/100ps

module pfs_mux
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write channels
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Pad levels seen by the input selectors, bit n is pin n
	input  wire logic [7:0]  pad_a_in,
	input  wire logic [7:0]  pad_b_in,
	input  wire logic [7:0]  pad_c_in,
	input  wire logic [7:0]  pad_d_in,
	input  wire logic [7:0]  pad_e_in,
	// Pad function codes, two bits per pin, pin n at bits 2n+1:2n
	output logic [15:0]      pad_d_func,
	output logic [15:0]      pad_e_func,
	output logic [15:0]      pad_f_func,
	// Route flags: one LCD flag per pin, one enable per alternate route
	output logic [7:0]       pad_d_lcd,
	output logic [7:0]       pad_e_lcd,
	output logic [7:0]       pad_f_lcd,
	output logic             module_serial_out_en,
	output logic             module_clock_out_en,
	output logic             std_timer_two_out_en,
	output logic             cmp_zero_out_en,
	output logic             compact_timer_zero_out_en,
	output logic             enh_timer_out_a_en,
	output logic             cmp_one_out_en,
	output logic             std_timer_one_out_en,
	output logic             second_port_serial_out_en,
	output logic             pd_analog_cmp_en,
	// Routed peripheral inputs
	output logic             peripheral_interrupt_in,
	output logic [3:0]       ext_irq_in,
	output logic             std_timer_zero_clock,
	output logic             std_timer_zero_capture,
	output logic             enh_timer_clock_in,
	output logic             enh_timer_capture_a,
	output logic             enh_timer_capture_b,
	output logic             compact_timer_zero_clock,
	output logic             std_timer_two_clock,
	output logic             std_timer_two_capture,
	output logic             std_timer_one_clock,
	output logic             std_timer_one_capture,
	output logic             compact_timer_one_clock,
	output logic             second_port_serial_in,
	output logic             second_port_clock,
	output logic             second_port_chip_select,
	output logic             module_serial_in,
	output logic             module_clock_in,
	output logic             module_chip_select,
	output logic             cmp_one_neg_in,
	output logic             cmp_one_pos_in,
	output logic             cmp_zero_neg_in,
	output logic             cmp_zero_pos_in
);
	import pfs_pkg::*;

	// ========================================
	// Register file
	logic [7:0]  port_d_func_sel_low;
	logic [7:0]  port_d_func_sel_high;
	logic [7:0]  port_e_func_sel_low;
	logic [7:0]  port_e_func_sel_high;
	logic [7:0]  port_f_func_sel_low;
	logic [7:0]  port_f_func_sel_high;
	logic [7:0]  interrupt_input_source_sel;
	logic [7:0]  timer_a_input_source_sel;
	logic [7:0]  timer_b_input_source_sel;
	logic [7:0]  serial_input_source_sel;
	logic [7:0]  comparator_input_source_sel;

	logic        aw_held;
	logic        w_held;
	logic [11:0] aw_addr;
	logic [7:0]  w_byte;
	logic        w_lane0;
	logic        do_write;
	logic        wr_hit;
	logic        rd_hit;
	logic [7:0]  rd_byte;

	// Address and data may arrive in either order; each is held until both are in
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// Write address channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
			s_axi_awready <= 1'b0;
		end
		else if (do_write)
		begin
			aw_held <= 1'b0;
			s_axi_awready <= 1'b0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_held && !s_axi_bvalid;
		end
	end

	// Write data channel; only the low lane carries register bits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else if (do_write)
		begin
			w_held <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_byte <= s_axi_wdata[7:0];
			w_lane0 <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_wready <= !w_held && !s_axi_bvalid;
		end
	end

	// Address decode for writes
	always_comb
	begin
		if (aw_addr == PFS_OFF_PD_LOW || aw_addr == PFS_OFF_PD_HIGH)
			wr_hit = 1'b1;
		else if (aw_addr == PFS_OFF_PE_LOW || aw_addr == PFS_OFF_PE_HIGH)
			wr_hit = 1'b1;
		else if (aw_addr == PFS_OFF_PF_LOW || aw_addr == PFS_OFF_PF_HIGH)
			wr_hit = 1'b1;
		else if (aw_addr == PFS_OFF_IRQ_SRC || aw_addr == PFS_OFF_TMA_SRC)
			wr_hit = 1'b1;
		else if (aw_addr == PFS_OFF_TMB_SRC || aw_addr == PFS_OFF_SER_SRC)
			wr_hit = 1'b1;
		else if (aw_addr == PFS_OFF_CMP_SRC)
			wr_hit = 1'b1;
		else
			wr_hit = 1'b0;
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PFS_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? PFS_RESP_OKAY : PFS_RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register storage; masks keep unimplemented bits at zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port_d_func_sel_low <= PFS_RESET_VAL;
			port_d_func_sel_high <= PFS_RESET_VAL;
			port_e_func_sel_low <= PFS_RESET_VAL;
			port_e_func_sel_high <= PFS_RESET_VAL;
			port_f_func_sel_low <= PFS_RESET_VAL;
			port_f_func_sel_high <= PFS_RESET_VAL;
			interrupt_input_source_sel <= PFS_RESET_VAL;
			timer_a_input_source_sel <= PFS_RESET_VAL;
			timer_b_input_source_sel <= PFS_RESET_VAL;
			serial_input_source_sel <= PFS_RESET_VAL;
			comparator_input_source_sel <= PFS_RESET_VAL;
		end
		else if (do_write && w_lane0)
		begin
			if (aw_addr == PFS_OFF_PD_LOW)
				port_d_func_sel_low <= w_byte;
			else if (aw_addr == PFS_OFF_PD_HIGH)
				port_d_func_sel_high <= w_byte;
			else if (aw_addr == PFS_OFF_PE_LOW)
				port_e_func_sel_low <= w_byte;
			else if (aw_addr == PFS_OFF_PE_HIGH)
				port_e_func_sel_high <= w_byte;
			else if (aw_addr == PFS_OFF_PF_LOW)
				port_f_func_sel_low <= w_byte;
			else if (aw_addr == PFS_OFF_PF_HIGH)
				port_f_func_sel_high <= w_byte;
			else if (aw_addr == PFS_OFF_IRQ_SRC)
				interrupt_input_source_sel <= w_byte & PFS_MASK_IRQ;
			else if (aw_addr == PFS_OFF_TMA_SRC)
				timer_a_input_source_sel <= w_byte & PFS_MASK_TMA;
			else if (aw_addr == PFS_OFF_TMB_SRC)
				timer_b_input_source_sel <= w_byte & PFS_MASK_TMB;
			else if (aw_addr == PFS_OFF_SER_SRC)
				serial_input_source_sel <= w_byte & PFS_MASK_SER;
			else if (aw_addr == PFS_OFF_CMP_SRC)
				comparator_input_source_sel <= w_byte & PFS_MASK_CMP;
		end
	end

	// Read decode
	always_comb
	begin
		rd_hit = 1'b1;
		if (s_axi_araddr == PFS_OFF_PD_LOW)
			rd_byte = port_d_func_sel_low;
		else if (s_axi_araddr == PFS_OFF_PD_HIGH)
			rd_byte = port_d_func_sel_high;
		else if (s_axi_araddr == PFS_OFF_PE_LOW)
			rd_byte = port_e_func_sel_low;
		else if (s_axi_araddr == PFS_OFF_PE_HIGH)
			rd_byte = port_e_func_sel_high;
		else if (s_axi_araddr == PFS_OFF_PF_LOW)
			rd_byte = port_f_func_sel_low;
		else if (s_axi_araddr == PFS_OFF_PF_HIGH)
			rd_byte = port_f_func_sel_high;
		else if (s_axi_araddr == PFS_OFF_IRQ_SRC)
			rd_byte = interrupt_input_source_sel;
		else if (s_axi_araddr == PFS_OFF_TMA_SRC)
			rd_byte = timer_a_input_source_sel;
		else if (s_axi_araddr == PFS_OFF_TMB_SRC)
			rd_byte = timer_b_input_source_sel;
		else if (s_axi_araddr == PFS_OFF_SER_SRC)
			rd_byte = serial_input_source_sel;
		else if (s_axi_araddr == PFS_OFF_CMP_SRC)
			rd_byte = comparator_input_source_sel;
		else
		begin
			rd_byte = 8'h00;
			rd_hit = 1'b0;
		end
	end

	// Read channel: arready idles high, data lands one cycle after the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= PFS_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_hit ? PFS_RESP_OKAY : PFS_RESP_SLVERR;
		end
		else if (s_axi_rvalid)
		begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
		else
		begin
			s_axi_arready <= 1'b1;
		end
	end

	// ========================================
	// Pad side decode, registered so every output comes from a flop
	logic [1:0] pd_code [8];
	logic [1:0] pe_code [8];
	logic [1:0] pf_code [8];

	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			pd_code[i] = port_d_func_sel_low[2*i +: 2];
			pd_code[i+4] = port_d_func_sel_high[2*i +: 2];
			pe_code[i] = port_e_func_sel_low[2*i +: 2];
			pe_code[i+4] = port_e_func_sel_high[2*i +: 2];
			pf_code[i] = port_f_func_sel_low[2*i +: 2];
			pf_code[i+4] = port_f_func_sel_high[2*i +: 2];
		end
	end

	// Segment enables: code 11 on every pad drives its LCD segment
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pad_d_lcd <= 8'h00;
			pad_e_lcd <= 8'h00;
			pad_f_lcd <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < 8; i++)
			begin
				pad_d_lcd[i] <= (pd_code[i] == PFS_FN_LCD);
				pad_e_lcd[i] <= (pe_code[i] == PFS_FN_LCD);
				pad_f_lcd[i] <= (pf_code[i] == PFS_FN_LCD);
			end
		end
	end

	// Raw codes for the pad cells; the odd PF pins keep whatever the cell makes of them
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pad_d_func <= 16'h0000;
			pad_e_func <= 16'h0000;
			pad_f_func <= 16'h0000;
		end
		else
		begin
			pad_d_func <= {port_d_func_sel_high, port_d_func_sel_low};
			pad_e_func <= {port_e_func_sel_high, port_e_func_sel_low};
			pad_f_func <= {port_f_func_sel_high, port_f_func_sel_low};
		end
	end

	// Alternate output routes on ports D and E
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			module_serial_out_en <= 1'b0;
			module_clock_out_en <= 1'b0;
			std_timer_two_out_en <= 1'b0;
			cmp_zero_out_en <= 1'b0;
			compact_timer_zero_out_en <= 1'b0;
			enh_timer_out_a_en <= 1'b0;
			cmp_one_out_en <= 1'b0;
			std_timer_one_out_en <= 1'b0;
			second_port_serial_out_en <= 1'b0;
			pd_analog_cmp_en <= 1'b0;
		end
		else
		begin
			module_serial_out_en <= (pd_code[3] == PFS_FN_ALT1);
			module_clock_out_en <= (pd_code[1] == PFS_FN_ALT1);
			std_timer_two_out_en <= (pd_code[7] == PFS_FN_ALT1);
			cmp_zero_out_en <= (pd_code[7] == PFS_FN_ALT2);
			compact_timer_zero_out_en <= (pd_code[5] == PFS_FN_ALT1);
			enh_timer_out_a_en <= (pd_code[4] == PFS_FN_ALT1);
			cmp_one_out_en <= (pd_code[4] == PFS_FN_ALT2);
			std_timer_one_out_en <= (pe_code[1] == PFS_FN_ALT2);
			second_port_serial_out_en <= (pe_code[0] == PFS_FN_ALT1);
			// Analog comparator inputs: PD3 PD1 PD6 PD5
			pd_analog_cmp_en <= (pd_code[3] == PFS_FN_ALT2) || (pd_code[1] == PFS_FN_ALT2)
				|| (pd_code[6] == PFS_FN_ALT2) || (pd_code[5] == PFS_FN_ALT2);
		end
	end

	// ========================================
	// Input source selection, one flop stage from the pads
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			peripheral_interrupt_in <= 1'b0;
			ext_irq_in <= 4'h0;
			std_timer_zero_clock <= 1'b0;
			std_timer_zero_capture <= 1'b0;
			enh_timer_clock_in <= 1'b0;
			enh_timer_capture_a <= 1'b0;
			enh_timer_capture_b <= 1'b0;
			compact_timer_zero_clock <= 1'b0;
			std_timer_two_clock <= 1'b0;
			std_timer_two_capture <= 1'b0;
			std_timer_one_clock <= 1'b0;
			std_timer_one_capture <= 1'b0;
			compact_timer_one_clock <= 1'b0;
			second_port_serial_in <= 1'b0;
			second_port_clock <= 1'b0;
			second_port_chip_select <= 1'b0;
			module_serial_in <= 1'b0;
			module_clock_in <= 1'b0;
			module_chip_select <= 1'b0;
			cmp_one_neg_in <= 1'b0;
			cmp_one_pos_in <= 1'b0;
			cmp_zero_neg_in <= 1'b0;
			cmp_zero_pos_in <= 1'b0;
		end
		else
		begin
			peripheral_interrupt_in <= interrupt_input_source_sel[7] ? pad_a_in[4] : pad_c_in[1];
			ext_irq_in[3] <= interrupt_input_source_sel[3] ? pad_d_in[4] : pad_b_in[3];
			ext_irq_in[2] <= interrupt_input_source_sel[2] ? pad_d_in[5] : pad_b_in[2];
			ext_irq_in[1] <= interrupt_input_source_sel[1] ? pad_d_in[6] : pad_a_in[7];
			ext_irq_in[0] <= interrupt_input_source_sel[0] ? pad_d_in[7] : pad_a_in[6];
			std_timer_zero_clock <= timer_a_input_source_sel[6] ? pad_c_in[7] : pad_b_in[2];
			std_timer_zero_capture <= timer_a_input_source_sel[5] ? pad_d_in[0] : pad_a_in[7];
			enh_timer_clock_in <= timer_a_input_source_sel[4] ? pad_d_in[1] : pad_a_in[6];
			enh_timer_capture_b <= timer_a_input_source_sel[3] ? pad_d_in[2] : pad_a_in[5];
			enh_timer_capture_a <= timer_a_input_source_sel[2] ? pad_d_in[4] : pad_a_in[4];
			compact_timer_zero_clock <= timer_a_input_source_sel[1] ? pad_d_in[4] : pad_a_in[3];
			std_timer_two_clock <= timer_b_input_source_sel[5] ? pad_d_in[6] : pad_c_in[1];
			std_timer_two_capture <= timer_b_input_source_sel[4] ? pad_d_in[7] : pad_c_in[2];
			std_timer_one_clock <= timer_b_input_source_sel[3] ? pad_e_in[0] : pad_c_in[3];
			std_timer_one_capture <= timer_b_input_source_sel[2] ? pad_e_in[1] : pad_c_in[4];
			compact_timer_one_clock <= timer_b_input_source_sel[1] ? pad_c_in[5] : pad_b_in[0];
			second_port_serial_in <= serial_input_source_sel[5] ? pad_e_in[1] : pad_c_in[5];
			module_serial_in <= serial_input_source_sel[4] ? pad_d_in[2] : pad_a_in[3];
			second_port_clock <= serial_input_source_sel[3] ? pad_c_in[6] : pad_b_in[1];
			module_clock_in <= serial_input_source_sel[2] ? pad_d_in[1] : pad_a_in[4];
			second_port_chip_select <= serial_input_source_sel[1] ? pad_c_in[7] : pad_b_in[0];
			module_chip_select <= serial_input_source_sel[0] ? pad_d_in[0] : pad_a_in[5];
			cmp_one_neg_in <= comparator_input_source_sel[4] ? pad_d_in[3] : pad_c_in[1];
			cmp_one_pos_in <= comparator_input_source_sel[3] ? pad_d_in[1] : pad_c_in[0];
			cmp_zero_neg_in <= comparator_input_source_sel[1] ? pad_d_in[6] : pad_c_in[7];
			cmp_zero_pos_in <= comparator_input_source_sel[0] ? pad_d_in[5] : pad_c_in[3];
		end
	end

endmodule : pfs_mux

// ### testbench/pfs_mux_assertions.sv
`timescale 1ns/100ps

// ========================================
// Pad routing checker
module pfs_mux_checker
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Write data handshake
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	// Pad routing
	input wire logic [15:0] pad_d_func,
	input wire logic [15:0] pad_e_func,
	input wire logic [15:0] pad_f_func,
	input wire logic [7:0]  pad_d_lcd,
	input wire logic [7:0]  pad_f_lcd,
	input wire logic        module_serial_out_en,
	input wire logic        std_timer_two_out_en,
	input wire logic        cmp_one_out_en,
	input wire logic        pd_analog_cmp_en,
	input wire logic        std_timer_one_out_en,
	input wire logic        second_port_serial_out_en
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Write data taken, used to explain any change of the port E pad codes
	wire logic w_taken = s_axi_wvalid && s_axi_wready;

	serial_out_route_a: assert property (module_serial_out_en == (pad_d_func[7:6] == 2'h1))
		else $error("serial out enable disagrees with pin code");
	timer_two_out_a: assert property (std_timer_two_out_en == (pad_d_func[15:14] == 2'h1))
		else $error("timer two out enable disagrees with pin code");
	cmp_one_out_a: assert property (cmp_one_out_en == (pad_d_func[9:8] == 2'h2))
		else $error("comparator one out enable disagrees with pin code");
	analog_in_route_a: assert property (pd_analog_cmp_en == ((pad_d_func[7:6] == 2'h2) ||
		(pad_d_func[3:2] == 2'h2) || (pad_d_func[13:12] == 2'h2) || (pad_d_func[11:10] == 2'h2)))
		else $error("analog enable disagrees with pin codes");
	timer_one_out_a: assert property (std_timer_one_out_en == (pad_e_func[3:2] == 2'h2))
		else $error("timer one out enable disagrees with pin code");
	second_serial_out_a: assert property (second_port_serial_out_en == (pad_e_func[1:0] == 2'h1))
		else $error("second port out enable disagrees with pin code");
	lcd_segment_flag_a: assert property ((pad_d_lcd[3] == (pad_d_func[7:6] == 2'h3)) &&
		(pad_f_lcd[6] == (pad_f_func[13:12] == 2'h3)))
		else $error("segment flag disagrees with pin code");
	reset_clear_a: assert property (!$past(aresetn) |->
		(pad_d_func == 16'h0000) && (pad_e_func == 16'h0000) && (pad_f_func == 16'h0000))
		else $error("pad codes not clear after reset");
	code_change_cause_a: assert property (!$stable(pad_e_func) |-> !$past(aresetn) ||
		$past(w_taken, 1) || $past(w_taken, 2) || $past(w_taken, 3) || $past(w_taken, 4))
		else $error("pad codes changed without a write");
endmodule : pfs_mux_checker

bind pfs_mux pfs_mux_checker pfs_mux_checker_i
(
	.aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.pad_d_func(pad_d_func), .pad_e_func(pad_e_func), .pad_f_func(pad_f_func),
	.pad_d_lcd(pad_d_lcd), .pad_f_lcd(pad_f_lcd), .module_serial_out_en(module_serial_out_en),
	.std_timer_two_out_en(std_timer_two_out_en), .cmp_one_out_en(cmp_one_out_en),
	.pd_analog_cmp_en(pd_analog_cmp_en), .std_timer_one_out_en(std_timer_one_out_en),
	.second_port_serial_out_en(second_port_serial_out_en)
);

// ### testbench/pfs_mux_test.sv
`timescale 1ns/100ps

module pfs_mux_test;
	import pfs_pkg::*;

	// ========================================
	// Design signals
	logic        aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  pa, pb, pc, pd, pe;
	logic [15:0] pad_d_func, pad_e_func, pad_f_func;
	logic [7:0]  pad_d_lcd, pad_e_lcd, pad_f_lcd;
	logic [9:0]  en;
	logic [25:0] rt;
	int          fails, samples_checked;

	pfs_mux pfs_mux_i
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pad_a_in(pa), .pad_b_in(pb), .pad_c_in(pc),
		.pad_d_in(pd), .pad_e_in(pe), .pad_d_func, .pad_e_func, .pad_f_func, .pad_d_lcd,
		.pad_e_lcd, .pad_f_lcd, .module_serial_out_en(en[9]), .module_clock_out_en(en[8]),
		.std_timer_two_out_en(en[7]), .cmp_zero_out_en(en[6]),
		.compact_timer_zero_out_en(en[5]), .enh_timer_out_a_en(en[4]), .cmp_one_out_en(en[3]),
		.std_timer_one_out_en(en[2]), .second_port_serial_out_en(en[1]),
		.pd_analog_cmp_en(en[0]), .cmp_zero_pos_in(rt[25]), .cmp_zero_neg_in(rt[24]),
		.cmp_one_pos_in(rt[23]), .cmp_one_neg_in(rt[22]), .module_chip_select(rt[21]),
		.module_clock_in(rt[20]), .module_serial_in(rt[19]), .second_port_chip_select(rt[18]),
		.second_port_clock(rt[17]), .second_port_serial_in(rt[16]),
		.compact_timer_one_clock(rt[15]), .std_timer_one_capture(rt[14]),
		.std_timer_one_clock(rt[13]), .std_timer_two_capture(rt[12]),
		.std_timer_two_clock(rt[11]), .compact_timer_zero_clock(rt[10]),
		.enh_timer_capture_a(rt[9]), .enh_timer_capture_b(rt[8]), .enh_timer_clock_in(rt[7]),
		.std_timer_zero_capture(rt[6]), .std_timer_zero_clock(rt[5]), .ext_irq_in(rt[4:1]),
		.peripheral_interrupt_in(rt[0])
	);

	// ========================================
	// Clock, 50 ns period
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// ========================================
	// Bus tasks; the extra edge at the end keeps two calls from driving in one step
	task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		while (s_axi_bvalid !== 1'b1 && n < 50);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50)
			fails++;
		@(posedge aclk);
	endtask : axi_write

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		while (s_axi_rvalid !== 1'b1 && n < 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 50)
			fails++;
		@(posedge aclk);
	endtask : axi_read

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_write(a, d, r);
		check("write resp", PFS_RESP_OKAY, r);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(a, d, r);
		check("read data", {24'h000000, e}, d);
		check("read resp", PFS_RESP_OKAY, r);
	endtask : rd_chk

	// Routed peripheral inputs for one selector value in every source register
	function automatic logic [25:0] exp_rt(input logic [7:0] s);
		return {s[0] ? pd[5] : pc[3], s[1] ? pd[6] : pc[7], s[3] ? pd[1] : pc[0],
			s[4] ? pd[3] : pc[1], s[0] ? pd[0] : pa[5], s[2] ? pd[1] : pa[4], s[4] ? pd[2] : pa[3],
			s[1] ? pc[7] : pb[0], s[3] ? pc[6] : pb[1], s[5] ? pe[1] : pc[5], s[1] ? pc[5] : pb[0],
			s[2] ? pe[1] : pc[4], s[3] ? pe[0] : pc[3], s[4] ? pd[7] : pc[2], s[5] ? pd[6] : pc[1],
			s[1] ? pd[4] : pa[3], s[2] ? pd[4] : pa[4], s[3] ? pd[2] : pa[5], s[4] ? pd[1] : pa[6],
			s[5] ? pd[0] : pa[7], s[6] ? pc[7] : pb[2], s[3] ? pd[4] : pb[3], s[2] ? pd[5] : pb[2],
			s[1] ? pd[6] : pa[7], s[0] ? pd[7] : pa[6], s[7] ? pa[4] : pc[1]};
	endfunction : exp_rt

	// Hang guard, far above the expected run of a few hundred cycles
	initial
	begin
		#1000000;
		fails++;
		report_and_stop();
	end

	// ========================================
	// Main sequence
	initial
	begin
		logic [7:0]  cd, sels[4], masks[5];
		logic [39:0] pats[3];
		logic [31:0] d;
		logic [1:0]  r;
		logic        c1, c2, c3;
		sels = '{8'h00, 8'hFF, 8'h55, 8'hAA};
		masks = '{PFS_MASK_IRQ, PFS_MASK_TMA, PFS_MASK_TMB, PFS_MASK_SER, PFS_MASK_CMP};
		// Every selectable source pair differs in at least one pattern
		pats = '{40'hF80D4D4802, ~40'hF80D4D4802, 40'h0000004000};
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		{pa, pb, pc, pd, pe} = '0;
		fails = 0;
		samples_checked = 0;
		aresetn = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 11; i++)
			rd_chk(12'(4 * i), 8'h00);
		// Same code on every pin of ports D, E and F; ends on general I/O, so the
		// pad function is settled before the input sources are chosen below
		for (int c = 3; c >= 0; c--)
		begin
			cd = {4{2'(c)}};
			c1 = (c == 1);
			c2 = (c == 2);
			c3 = (c == 3);
			for (int i = 0; i < 6; i++)
				wr(12'(4 * i), cd);
			for (int i = 0; i < 6; i++)
				rd_chk(12'(4 * i), cd);
			check("pad enables", {c1, c1, c1, c2, c1, c1, c2, c2, c1, c2}, en);
			check("lcd flags", {24{c3}}, {pad_d_lcd, pad_e_lcd, pad_f_lcd});
			check("pad codes", {6{cd}}, {pad_d_func, pad_e_func, pad_f_func});
		end
		// Input source selectors against several pad patterns
		foreach (sels[k])
		begin
			for (int i = 0; i < 5; i++)
			begin
				wr(PFS_OFF_IRQ_SRC + 12'(4 * i), sels[k]);
				rd_chk(PFS_OFF_IRQ_SRC + 12'(4 * i), sels[k] & masks[i]);
			end
			foreach (pats[p])
			begin
				{pa, pb, pc, pd, pe} <= pats[p];
				repeat (3) @(posedge aclk);
				check("routed inputs", exp_rt(sels[k]), rt);
			end
		end
		// Unmapped address refused both ways
		axi_write(12'h02C, 8'h5A, r);
		check("unmapped write resp", PFS_RESP_SLVERR, r);
		axi_read(12'h02C, d, r);
		check("unmapped read resp", PFS_RESP_SLVERR, r);
		check("unmapped read data", 32'h00000000, d);
		// Reset in mid-run clears every field again
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 11; i++)
			rd_chk(12'(4 * i), 8'h00);
		report_and_stop();
	end
endmodule : pfs_mux_test
